// *** pkg/jk_if.sv ***
// Purpose: Carrier between the array and one J-K flip-flop bank
// Assumes: All signals on clk_i
// Notes:   en is the machine clock enable
`timescale 1ns/1ps
interface jk_if #(parameter int W = 8);
    logic [W-1:0] j;
    logic [W-1:0] k;
    logic         en;
    logic [W-1:0] q;
    modport array (output j, output k, output en, input q);
    modport bank  (input j, input k, input en, output q);
endinterface : jk_if

// *** pkg/seq_pkg.sv ***
// Purpose: Shared sizes and constants of the dual J-K sequencer
// Assumes: One clock; per-machine clocking is an enable
// Notes:   Flip-flop index 0..3 buried, 4..7 exposed
package seq_pkg;
    localparam int N_MACH     = 2;
    localparam int N_BURIED   = 4;
    localparam int N_EXPOSED  = 4;
    localparam int N_FF       = N_BURIED + N_EXPOSED;
    localparam int N_PT       = 64;
    localparam int N_IN       = 8;
    localparam int EXP_LSB    = N_BURIED;
    localparam logic RST_FF   = 1'b0;
    localparam logic RST_OE   = 1'b0;
    localparam logic RST_SLP  = 1'b0;
endpackage : seq_pkg

// *** test/dual_sequencer_asserts.sv ***
// Purpose: Port checks of the dual sequencer
// Assumes: Latencies as handed over
// Notes:   Bound from the bench
`timescale 1ns/1ps
module dual_sequencer_asserts (
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic [1:0] mach_clk_en_i,
    input wire logic [1:0] out_en_i,
    input wire logic       core_sleep_request_i,
    input wire logic [7:0] out_o,
    input wire logic [7:0] out_oe_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_oe; out_oe_o == {{4{$past(out_en_i[1])}}, {4{$past(out_en_i[0])}}}; endproperty
    a_oe: assert property (p_oe) else $error("oe lag");
    property p_h0; !mach_clk_en_i[0] |=> $stable(out_o[3:0]); endproperty
    a_h0: assert property (p_h0) else $error("m0 moved");
    property p_h1; !mach_clk_en_i[1] |=> $stable(out_o[7:4]); endproperty
    a_h1: assert property (p_h1) else $error("m1 moved");
    property p_slp; core_sleep_request_i ##1 1 |=> $stable(out_o); endproperty
    a_slp: assert property (p_slp) else $error("moved asleep");
    property p_wk; $fell(core_sleep_request_i) |=> $stable(out_o); endproperty
    a_wk: assert property (p_wk) else $error("woke early");
    property p_o0; $rose(out_en_i[0]) && $stable(out_en_i[1]) |=> $stable(out_oe_o[7:4]); endproperty
    a_o0: assert property (p_o0) else $error("oe coupled");
    property p_o1; $fell(out_en_i[1]) |=> out_oe_o[7:4] == 4'h0; endproperty
    a_o1: assert property (p_o1) else $error("oe stuck");
    property p_rst; $past(rst_i) |-> out_o == 8'h00; endproperty
    a_rst: assert property (p_rst) else $error("not cleared");
    c_slp: cover property (core_sleep_request_i ##1 core_sleep_request_i);
    c_en: cover property (mach_clk_en_i == 2'h3);
    c_oe: cover property ($rose(out_oe_o[4]));
endmodule : dual_sequencer_asserts

// *** test/dual_sequencer_bench.sv ***
// Purpose: Self-checking bench of the dual sequencer
// Assumes: All terms without literals read true
// Notes:   Enable pulses give single machine clocks
`timescale 1ns/1ps
module dual_sequencer_bench;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] in_i = 8'h00;
    logic [1:0] en = 2'h0;
    logic [1:0] oe = 2'h0;
    logic cmd = 1'b0;
    logic slp;
    logic [63:0][25:0] pt_t = '0;
    logic [63:0][25:0] pt_c = '0;
    logic [1:0][7:0][63:0] jc = '0;
    logic [1:0][7:0][63:0] kc = '0;
    logic [1:0][63:0] ec = '0;
    logic [7:0] out_o;
    logic [7:0] out_oe_o;
    logic [7:0] v;
    int error_cnt = 0;
    int check_count = 0;
    int s[7] = '{2, 0, 3, 0, 1, 3, 1};
    always #20 clk_i = ~clk_i;
    sys_drive i_sys (.clk_i(clk_i), .sleep_cmd_i(cmd), .core_sleep_request_o(slp));
    dual_sequencer i_dut (.clk_i(clk_i), .rst_i(rst_i), .in_i(in_i), .mach_clk_en_i(en),
        .out_en_i(oe), .core_sleep_request_i(slp), .pt_true_i(pt_t), .pt_comp_i(pt_c),
        .j_conn_i(jc), .k_conn_i(kc), .else_conn_i(ec), .out_o(out_o), .out_oe_o(out_oe_o));
    task chk(input string n, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : tick
    task pulse;
        @(posedge clk_i);
        en[0] <= 1'b1;
        @(posedge clk_i);
        en[0] <= 1'b0;
        #1;
    endtask : pulse
    task t_jk;
        logic q;
        q = 1'b0;
        foreach (s[i]) begin
            @(posedge clk_i);
            jc[0][4][0] <= s[i][1];
            kc[0][4][0] <= s[i][0];
            pulse();
            q = (s[i][1] & ~q) | (~s[i][0] & q);
            chk("jk", {7'h00, q}, out_o);
        end
    endtask : t_jk
    task t_else;
        @(posedge clk_i);
        in_i <= 8'h01;
        pt_t[1][24] <= 1'b1;
        pt_t[2][0] <= 1'b1;
        ec[0][2] <= 1'b1;
        jc[0][5][1] <= 1'b1;
        pulse();
        chk("else_off", 8'h00, out_o);
        @(posedge clk_i);
        in_i <= 8'h00;
        pulse();
        chk("else_on", 8'h02, out_o);
    endtask : t_else
    task t_bury;
        @(posedge clk_i);
        jc[0][0][0] <= 1'b1;
        pt_t[4][8] <= 1'b1;
        pt_c[4][1] <= 1'b1;
        jc[0][6][4] <= 1'b1;
        in_i <= 8'h02;
        pulse();
        chk("buried_hidden", 8'h02, out_o);
        pulse();
        chk("comp_lit", 8'h02, out_o);
        @(posedge clk_i);
        in_i <= 8'h00;
        pulse();
        chk("buried_fed", 8'h06, out_o);
    endtask : t_bury
    task t_sleep;
        @(posedge clk_i);
        jc[1][4][0] <= 1'b1;
        kc[1][4][0] <= 1'b1;
        en <= 2'h2;
        @(posedge clk_i);
        cmd <= 1'b1;
        tick(4);
        v = out_o;
        tick(3);
        chk("asleep", v, out_o);
        @(posedge clk_i);
        cmd <= 1'b0;
        tick(4);
        v = out_o;
        tick(1);
        chk("awake", v ^ 8'h10, out_o);
    endtask : t_sleep
    task t_oe;
        for (int i = 0; i < 5; i++) begin
            @(posedge clk_i);
            oe <= 2'(i);
            tick(1);
            chk("oe", {{4{i[1]}}, {4{i[0]}}} & 8'hff, out_oe_o);
        end
    endtask : t_oe
    task results;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : results
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        tick(1);
        chk("rst", 8'h00, out_o);
        t_jk();
        t_else();
        t_bury();
        t_sleep();
        t_oe();
        results();
    end
endmodule : dual_sequencer_bench
bind dual_sequencer dual_sequencer_asserts i_chk (.clk_i(clk_i), .rst_i(rst_i),
    .mach_clk_en_i(mach_clk_en_i), .out_en_i(out_en_i),
    .core_sleep_request_i(core_sleep_request_i), .out_o(out_o), .out_oe_o(out_oe_o));

// *** test/sys_drive.sv ***
// Purpose: Surrounding logic pacing the sleep request
// Assumes: Level command from the bench
// Notes:   Request moves only after a clock edge
`timescale 1ns/1ps
module sys_drive (
    input  wire logic clk_i,
    input  wire logic sleep_cmd_i,
    output logic      core_sleep_request_o
);
    initial core_sleep_request_o = 1'b0;
    always @(posedge clk_i) begin
        core_sleep_request_o <= sleep_cmd_i;
    end
endmodule : sys_drive

// *** verilog/dual_sequencer.sv ***
// Purpose: Dual programmable J-K state-machine sequencer
// Assumes: Array connections arrive as static configuration ports
// Notes:   Machine clocks are enables on clk_i
//          Literal order from bit 0: inputs, machine 0 flops, machine 1 flops, else terms
//          Flops 0..3 of a machine are buried, 4..7 exposed
//          A term with no literal selected reads true
//          True and complement both selected on one literal: term never true
//          Terms feeding an else NOR must not use else literals
//          Sleep request acts from the edge after the one that takes it
//          Output enables follow their requests one edge later
//          Array connections are static while the machines run
//
// Summary of operation
// - Two machines, each four buried and four exposed J-K flops on one clock.
// - Exposed flops drive pins; buried flops feed only the array.
// - Sixty-four product terms, freely connectable to any flop input of either machine.
// - No asserted transition term means the machine holds its state.
// - Complement term is a NOR of selected terms, fed back into array.
// - Exactly one complement term per machine, giving else-transitions.
// - Separate clock enables and output enables per machine.
// - Sleep request high freezes the core; release resumes with state kept.
`timescale 1ns/1ps
module dual_sequencer #(
    parameter int N_IN = seq_pkg::N_IN,
    parameter int N_PT = seq_pkg::N_PT
) (
    input  wire logic                                                   clk_i,
    input  wire logic                                                   rst_i,
    input  wire logic [N_IN-1:0]                                        in_i,
    input  wire logic [seq_pkg::N_MACH-1:0]                             mach_clk_en_i,
    input  wire logic [seq_pkg::N_MACH-1:0]                             out_en_i,
    input  wire logic                                                   core_sleep_request_i,
    input  wire logic [N_PT-1:0][N_IN+seq_pkg::N_MACH*seq_pkg::N_FF+seq_pkg::N_MACH-1:0]
                                                                        pt_true_i,
    input  wire logic [N_PT-1:0][N_IN+seq_pkg::N_MACH*seq_pkg::N_FF+seq_pkg::N_MACH-1:0]
                                                                        pt_comp_i,
    input  wire logic [seq_pkg::N_MACH-1:0][seq_pkg::N_FF-1:0][N_PT-1:0] j_conn_i,
    input  wire logic [seq_pkg::N_MACH-1:0][seq_pkg::N_FF-1:0][N_PT-1:0] k_conn_i,
    input  wire logic [seq_pkg::N_MACH-1:0][N_PT-1:0]                   else_conn_i,
    output logic      [seq_pkg::N_MACH*seq_pkg::N_EXPOSED-1:0]          out_o,
    output logic      [seq_pkg::N_MACH*seq_pkg::N_EXPOSED-1:0]          out_oe_o
);

    localparam int NM       = seq_pkg::N_MACH;
    localparam int NF       = seq_pkg::N_FF;
    localparam int NE       = seq_pkg::N_EXPOSED;
    localparam int NB       = seq_pkg::N_BURIED;
    localparam int NQ       = NM * NF;
    localparam int L        = N_IN + NQ + NM;
    localparam int LIT_Q    = N_IN;
    localparam int LIT_ELSE = N_IN + NQ;
    localparam logic [L-1:0] FIRST_PASS = {{NM{1'b0}}, {(N_IN + NQ){1'b1}}};

    // ------------------------------------------------
    // State
    // ------------------------------------------------
    typedef struct packed {
        logic                 sleep;
        logic [NM*NE-1:0]     oe;
    } top_s;

    top_s st_q;
    top_s st_d;

    // ------------------------------------------------
    // Nets
    // ------------------------------------------------
    // Flop views
    logic [NQ-1:0]           q_all;
    logic [NM-1:0][NB-1:0]   buried_q;
    logic [NM-1:0][NE-1:0]   exposed_q;

    // Clocking
    logic [NM-1:0]           mach_tick;

    // Array literals and terms
    logic [NM-1:0]           else_term;
    logic [L-1:0]            lit;
    logic [L-1:0]            lit_a;
    logic [N_PT-1:0][L-1:0]  true_a;
    logic [N_PT-1:0][L-1:0]  comp_a;
    logic [N_PT-1:0]         true_ok_a;
    logic [N_PT-1:0]         comp_ok_a;
    logic [N_PT-1:0]         true_ok_b;
    logic [N_PT-1:0]         comp_ok_b;
    logic [N_PT-1:0]         pt_a;
    logic [N_PT-1:0]         pt_b;

    // Flop inputs
    logic [NM-1:0][NF-1:0]   j_or;
    logic [NM-1:0][NF-1:0]   k_or;

    jk_if #(.W(NF)) bank_if [NM] ();

    genvar p;
    genvar m;
    genvar f;

    // ------------------------------------------------
    // Array literals
    // ------------------------------------------------
    // Second pass sees every literal
    assign lit[0 +: N_IN]          = in_i;
    assign lit[LIT_Q +: NQ]        = q_all;
    assign lit[LIT_ELSE +: NM]     = else_term;
    // First pass sees no else literal, so the NOR cannot loop
    assign lit_a[0 +: N_IN]        = in_i;
    assign lit_a[LIT_Q +: NQ]      = q_all;
    assign lit_a[LIT_ELSE +: NM]   = {NM{1'b0}};

    // ------------------------------------------------
    // Product terms, two passes
    // ------------------------------------------------
    generate
        for (p = 0; p < N_PT; p++) begin : g_pt
            // First pass excludes else literals
            assign true_a[p]    = pt_true_i[p] & FIRST_PASS;
            assign comp_a[p]    = pt_comp_i[p] & FIRST_PASS;
            assign true_ok_a[p] = &(~true_a[p] | lit_a);
            assign comp_ok_a[p] = &(~comp_a[p] | ~lit_a);
            assign pt_a[p]      = true_ok_a[p] & comp_ok_a[p];

            // Shared pool, any term to any flop
            assign true_ok_b[p] = &(~pt_true_i[p] | lit);
            assign comp_ok_b[p] = &(~pt_comp_i[p] | ~lit);
            assign pt_b[p]      = true_ok_b[p] & comp_ok_b[p];
        end
    endgenerate

    // ------------------------------------------------
    // Complement terms
    // ------------------------------------------------
    generate
        for (m = 0; m < NM; m++) begin : g_else
            // One NOR else term per machine
            assign else_term[m] = ~|(pt_a & else_conn_i[m]);
        end
    endgenerate

    // ------------------------------------------------
    // Flop input OR gates
    // ------------------------------------------------
    generate
        for (m = 0; m < NM; m++) begin : g_or
            for (f = 0; f < NF; f++) begin : g_ff
                // Any term into any flop input
                assign j_or[m][f] = |(pt_b & j_conn_i[m][f]);
                assign k_or[m][f] = |(pt_b & k_conn_i[m][f]);
            end
        end
    endgenerate

    // ------------------------------------------------
    // Machine clocks
    // ------------------------------------------------
    generate
        for (m = 0; m < NM; m++) begin : g_tick
            // Own clock enable, frozen while asleep
            assign mach_tick[m] = mach_clk_en_i[m] & ~st_q.sleep;
        end
    endgenerate

    // ------------------------------------------------
    // Machines
    // ------------------------------------------------
    generate
        for (m = 0; m < NM; m++) begin : g_mach
            // Array to bank carrier
            assign bank_if[m].j  = j_or[m];
            assign bank_if[m].k  = k_or[m];
            assign bank_if[m].en = mach_tick[m];

            // Eight flops on one enable form one machine
            jk_bank #(
                .W (NF)
            ) u_bank (
                .clk_i (clk_i),
                .rst_i (rst_i),
                .port  (bank_if[m])
            );

            assign buried_q[m]       = bank_if[m].q[0 +: NB];
            assign exposed_q[m]      = bank_if[m].q[seq_pkg::EXP_LSB +: NE];
            // Buried and exposed flops all feed back as state variables
            assign q_all[m*NF +: NF] = {exposed_q[m], buried_q[m]};
            // Exposed flops straight to pins
            assign out_o[m*NE +: NE] = exposed_q[m];
        end
    endgenerate

    // ------------------------------------------------
    // Sleep and output enables
    // ------------------------------------------------
    always_comb begin
        st_d       = st_q;
        // Request taken at the clock edge
        st_d.sleep = core_sleep_request_i;
        for (int i = 0; i < NM; i++) begin
            // Independent three-state control per machine
            st_d.oe[i*NE +: NE] = {NE{out_en_i[i]}};
        end
    end

    // Asynchronous clear, then one register for the whole state
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_q.sleep <= seq_pkg::RST_SLP;
            st_q.oe    <= {(NM*NE){seq_pkg::RST_OE}};
        end else begin
            st_q <= st_d;
        end
    end


    // ------------------------------------------------
    // Outputs
    // ------------------------------------------------
    // Registered enables, one edge behind request
    assign out_oe_o = st_q.oe;
endmodule : dual_sequencer

// *** verilog/jk_bank.sv ***
// Purpose: One bank of J-K flip-flops sharing one clock enable
// Assumes: Enable already gated by sleep
// Notes:   State held while enable low
`timescale 1ns/1ps
module jk_bank #(
    parameter int W = 8
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    jk_if.bank        port
);
    typedef struct packed {
        logic [W-1:0] q;
    } bank_s;

    bank_s st_q;
    bank_s st_d;

    // ------------------------------------------------
    // Next state
    // ------------------------------------------------
    always_comb begin
        st_d = st_q;
        if (port.en) begin
            // Hold, set, clear, toggle
            st_d.q = (port.j & ~st_q.q) | (~port.k & st_q.q);
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_q.q <= {W{seq_pkg::RST_FF}};
        end else begin
            st_q <= st_d;
        end
    end

    assign port.q = st_q.q;
endmodule : jk_bank
